// File: core/interrupt_priority_privilege.v
// interrupt priority stack, privilege shadow, flags and vector bases
// assumes the core issues one instruction at a time and waits on ownDone
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "interrupt_priority_privilege_regs.vh"
module interrupt_priority_privilege (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // instruction issue
  input  wire        instStart,
  input  wire [7:0]  op0,
  input  wire [7:0]  op1,
  input  wire        altdIn,
  input  wire        ioiIn,
  input  wire        ioeIn,
  input  wire [1:0]  extAltClass,
  input  wire [1:0]  extIoClass,
  input  wire        coreEnd,
  output wire        instOwn,
  output wire        instIllegal,
  output wire        altFlags,
  output wire        altReg,
  output wire        ioSrc,
  output wire        ioDst,
  output wire        ready,
  output reg         ownDone_r,
  // core register values
  input  wire [15:0] spIn,
  input  wire [15:0] hlIn,
  input  wire [15:0] pcIn,
  input  wire [7:0]  accIn,
  output reg         spLoad_r,
  output reg  [15:0] spNext_r,
  output reg         pcLoad_r,
  output reg  [15:0] pcNext_r,
  output reg         accLoad_r,
  output reg         accAlt_r,
  output reg  [7:0]  accNext_r,
  // flag sources
  input  wire        logicValid,
  input  wire        logicAlt,
  input  wire [7:0]  logicResult,
  input  wire        afLoad,
  input  wire        afAlt,
  input  wire [7:0]  afData,
  output reg  [7:0]  flags_r,
  output reg  [7:0]  flagsAlt_r,
  // memory port, read data one cycle after memRd
  output reg         memRd_r,
  output reg         memWr_r,
  output reg  [15:0] memAddr_r,
  output reg  [7:0]  memWdata_r,
  output reg  [1:0]  memIo_r,
  input  wire [7:0]  memRdata,
  // interrupt request
  input  wire        irqReq,
  input  wire [1:0]  irqLevel,
  input  wire        irqExternal,
  input  wire [7:0]  irqOffset,
  output reg         irqTake_r,
  output reg  [15:0] irqVector_r,
  // avalon-mm slave
  input  wire [2:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]  prio_r;
  reg  [7:0]  extVb_r;
  reg  [7:0]  intVb_r;
  reg         irqEn_r;
  reg         shadow_r;
  reg         busy_r;
  reg  [3:0]  cls_r;
  reg  [3:0]  cnt_r;
  reg  [3:0]  lim_r;
  reg         priv_r;
  reg         alt_r;
  reg  [1:0]  ioSel_r;
  reg  [1:0]  ioCls_r;
  reg  [7:0]  opB_r;
  reg  [15:0] sp_r;
  reg  [15:0] hl_r;
  reg  [15:0] pc_r;
  reg  [7:0]  acc_r;
  reg  [7:0]  pcl_r;
  reg         ack_r;
  wire [3:0]  cls;
  wire        priv;
  wire        illegal;
  wire [1:0]  altClass;
  wire [1:0]  ioClass;
  reg  [3:0]  lim;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  opcode_classifier opcode_classifier_inst (
    .op0         (op0),
    .op1         (op1),
    .extAltClass (extAltClass),
    .extIoClass  (extIoClass),
    .cls         (cls),
    .privileged  (priv),
    .illegal     (illegal),
    .altClass    (altClass),
    .ioClass     (ioClass)
  );
  // prefix routing toward the rest of the core
  assign altFlags    = altdIn & altClass[1];
  assign altReg      = altdIn & altClass[0];
  assign ioSrc       = (ioiIn | ioeIn) & ioClass[1];
  assign ioDst       = (ioiIn | ioeIn) & ioClass[0];
  assign instIllegal = illegal;
  assign instOwn     = !illegal && cls != `CL_NONE && cls != `CL_EXSP;
  assign ready       = !busy_r;
  // clocks taken by each owned class
  always @* begin
    case (cls)
      `CL_PRIORITY_PUSH_OP, `CL_PRIORITY_POP_OP: lim = `CLK_IPOP;
      `CL_POPIP:  lim = `CLK_POPIP;
      `CL_PUSHIP: lim = `CLK_PUSHIP;
      `CL_RETI:   lim = `CLK_RETI;
      `CL_CCF, `CL_SCF: lim = `CLK_CARRY;
      `CL_BIT:    lim = `CLK_BIT;
      `CL_SET:    lim = `CLK_SET;
      `CL_RST:    lim = `CLK_RST;
      default:    lim = `CLK_LDVB;
    endcase
  end
  // ----------------------------------------------------------------
  // boundary and interrupt gating
  // ----------------------------------------------------------------
  wire lastCyc  = busy_r && cnt_r == lim_r;
  wire boundary = lastCyc || coreEnd;
  wire allow    = !shadow_r && !priv_r;
  wire irqWin   = boundary && allow && irqEn_r && irqReq && irqLevel > prio_r[1:0];
  wire bitZero  = !memRdata[opB_r[5:3]];
  wire [7:0] bitMask = 8'h01 << opB_r[5:3];
  wire [7:0] flSel  = alt_r ? flagsAlt_r : flags_r;
  // ----------------------------------------------------------------
  // sequencer: timing, memory requests, stack and pc updates
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r     <= 1'b0;
      cls_r      <= `CL_NONE;
      cnt_r      <= 4'h0;
      lim_r      <= 4'h0;
      priv_r     <= 1'b0;
      alt_r      <= 1'b0;
      ioSel_r    <= 2'h0;
      ioCls_r    <= 2'h0;
      opB_r      <= 8'h00;
      sp_r       <= 16'h0000;
      hl_r       <= 16'h0000;
      pc_r       <= 16'h0000;
      acc_r      <= 8'h00;
      pcl_r      <= 8'h00;
      shadow_r   <= 1'b0;
      ownDone_r  <= 1'b0;
      spLoad_r   <= 1'b0;
      spNext_r   <= 16'h0000;
      pcLoad_r   <= 1'b0;
      pcNext_r   <= 16'h0000;
      memRd_r    <= 1'b0;
      memWr_r    <= 1'b0;
      memAddr_r  <= 16'h0000;
      memWdata_r <= 8'h00;
      memIo_r    <= 2'h0;
      irqTake_r  <= 1'b0;
      irqVector_r <= 16'h0000;
    end else begin
      ownDone_r <= 1'b0;
      spLoad_r  <= 1'b0;
      pcLoad_r  <= 1'b0;
      memRd_r   <= 1'b0;
      memWr_r   <= 1'b0;
      irqTake_r <= irqWin;
      if (irqWin)
        irqVector_r <= {irqExternal ? extVb_r : intVb_r, irqOffset};
      // privilege shadow moves one instruction at each boundary
      if (boundary) begin
        shadow_r <= priv_r;
        priv_r   <= 1'b0;
      end
      if (instStart && !busy_r) begin
        priv_r  <= priv;
        alt_r   <= altdIn;
        ioSel_r <= {ioeIn, ioiIn};
        ioCls_r <= ioClass;
        opB_r   <= cls == `CL_RST ? op0 : op1; // restart vector sits in the first byte
        sp_r    <= spIn;
        hl_r    <= hlIn;
        pc_r    <= pcIn;
        acc_r   <= accIn;
        if (instOwn) begin
          busy_r <= 1'b1;
          cls_r  <= cls;
          cnt_r  <= 4'h1;
          lim_r  <= lim - 4'h1; // last busy cycle, so done lands on the count
          // first memory request leaves with the start
          case (cls)
            `CL_POPIP, `CL_RETI: begin
              memRd_r   <= 1'b1;
              memAddr_r <= spIn;
              memIo_r   <= 2'h0;
            end
            `CL_BIT, `CL_SET: begin
              memRd_r   <= 1'b1;
              memAddr_r <= hlIn;
              memIo_r   <= ioClass[1] ? {ioeIn, ioiIn} : 2'h0;
            end
            `CL_PUSHIP: begin
              memWr_r    <= 1'b1;
              memAddr_r  <= spIn - 16'h0001;
              memWdata_r <= prio_r;
              memIo_r    <= 2'h0;
            end
            `CL_RST: begin
              memWr_r    <= 1'b1;
              memAddr_r  <= spIn - 16'h0001;
              memWdata_r <= pcIn[15:8];
              memIo_r    <= 2'h0;
            end
            default: memIo_r <= 2'h0;
          endcase
        end
      end else if (busy_r) begin
        cnt_r <= cnt_r + 4'h1;
        // follow-on requests of multi-byte classes
        if (cnt_r == 4'h1 && cls_r == `CL_RETI) begin
          memRd_r   <= 1'b1;
          memAddr_r <= sp_r + 16'h0001;
        end
        if (cnt_r == 4'h1 && cls_r == `CL_RST) begin
          memWr_r    <= 1'b1;
          memAddr_r  <= sp_r - 16'h0002;
          memWdata_r <= pc_r[7:0];
        end
        if (cnt_r == 4'h2 && cls_r == `CL_RETI) begin
          memRd_r   <= 1'b1;
          memAddr_r <= sp_r + 16'h0002;
        end
        if (cnt_r == 4'h3 && cls_r == `CL_RETI)
          pcl_r <= memRdata;
        if (cnt_r == 4'h4 && cls_r == `CL_RETI)
          pcNext_r <= {memRdata, pcl_r};
        if (cnt_r == 4'h2 && cls_r == `CL_SET) begin
          memWr_r    <= 1'b1;
          memAddr_r  <= hl_r;
          memWdata_r <= memRdata | bitMask;
          memIo_r    <= ioCls_r[0] ? ioSel_r : 2'h0;
        end
        if (lastCyc) begin
          busy_r    <= 1'b0;
          ownDone_r <= 1'b1;
          case (cls_r)
            `CL_POPIP: begin
              spLoad_r <= 1'b1;
              spNext_r <= sp_r + 16'h0001;
            end
            `CL_PUSHIP: begin
              spLoad_r <= 1'b1;
              spNext_r <= sp_r - 16'h0001;
            end
            `CL_RETI: begin
              spLoad_r <= 1'b1;
              spNext_r <= sp_r + 16'h0003;
              pcLoad_r <= 1'b1;
            end
            `CL_RST: begin
              spLoad_r <= 1'b1;
              spNext_r <= sp_r - 16'h0002;
              pcLoad_r <= 1'b1;
              pcNext_r <= {intVb_r, 1'b0, opB_r[5:3], 4'h0};
            end
            default: spLoad_r <= 1'b0;
          endcase
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // priority stack, vector bases, control; instruction wins over bus
  // ----------------------------------------------------------------
  wire busWr = write && ack_r && byteenable[0];
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prio_r    <= `RST_PRIO;
      extVb_r   <= `RST_VB;
      intVb_r   <= `RST_VB;
      irqEn_r   <= `RST_CTRL;
      accLoad_r <= 1'b0;
      accAlt_r  <= 1'b0;
      accNext_r <= 8'h00;
    end else begin
      accLoad_r <= 1'b0;
      if (busWr && address == `OFS_CTRL)
        irqEn_r <= writedata[`CTRL_IRQEN];
      if (irqTake_r)
        prio_r <= {prio_r[5:0], irqLevel};
      else if (busy_r && cnt_r == 4'h1 && cls_r == `CL_PRIORITY_PUSH_OP)
        prio_r <= {prio_r[5:0], opB_r[4], opB_r[3]};
      else if (busy_r && cnt_r == 4'h1 && cls_r == `CL_PRIORITY_POP_OP)
        prio_r <= {prio_r[1:0], prio_r[7:2]};
      else if (busy_r && cnt_r == 4'h2 && (cls_r == `CL_POPIP || cls_r == `CL_RETI))
        prio_r <= memRdata;
      else if (busWr && address == `OFS_PRIO)
        prio_r <= writedata[7:0];
      if (busy_r && cnt_r == 4'h1 && cls_r == `CL_LDEA)
        extVb_r <= acc_r;
      else if (busWr && address == `OFS_EXTVB)
        extVb_r <= writedata[7:0];
      if (busy_r && cnt_r == 4'h1 && cls_r == `CL_LDIA)
        intVb_r <= acc_r;
      else if (busWr && address == `OFS_INTVB)
        intVb_r <= writedata[7:0];
      if (busy_r && cnt_r == 4'h1 && (cls_r == `CL_LDAE || cls_r == `CL_LDAI)) begin
        accLoad_r <= 1'b1;
        accAlt_r  <= alt_r;
        accNext_r <= cls_r == `CL_LDAE ? extVb_r : intVb_r;
      end
    end
  end
  // ----------------------------------------------------------------
  // flags: main and alternate sets
  // ----------------------------------------------------------------
  reg [7:0] flUpd;
  reg       flHit;
  always @* begin
    flUpd = flSel;
    flHit = 1'b0;
    if (busy_r && cnt_r == 4'h1) begin
      case (cls_r)
        `CL_CCF: begin flUpd[`FLG_C] = !flSel[`FLG_C]; flHit = 1'b1; end
        `CL_SCF: begin flUpd[`FLG_C] = 1'b1; flHit = 1'b1; end
        `CL_LDAE, `CL_LDAI: begin
          flUpd[`FLG_S] = cls_r == `CL_LDAE ? extVb_r[7] : intVb_r[7];
          flUpd[`FLG_Z] = (cls_r == `CL_LDAE ? extVb_r : intVb_r) == 8'h00;
          flHit = 1'b1;
        end
        default: flHit = 1'b0;
      endcase
    end
    if (busy_r && cnt_r == 4'h2 && cls_r == `CL_BIT) begin
      flUpd[`FLG_Z] = bitZero;
      flHit = 1'b1;
    end
  end
  // set of bits in memory never reaches here: flags stay as the bit test left them
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_r    <= `RST_FLAGS;
      flagsAlt_r <= `RST_FLAGS;
    end else begin
      if (flHit && !alt_r)
        flags_r <= flUpd;
      else if (logicValid && !logicAlt) begin
        flags_r[`FLG_S]  <= logicResult[7];
        flags_r[`FLG_Z]  <= logicResult == 8'h00;
        flags_r[`FLG_LV] <= |logicResult[7:4];
      end else if (afLoad && !afAlt)
        flags_r <= afData;
      if (flHit && alt_r)
        flagsAlt_r <= flUpd;
      else if (logicValid && logicAlt) begin
        flagsAlt_r[`FLG_S]  <= logicResult[7];
        flagsAlt_r[`FLG_Z]  <= logicResult == 8'h00;
        flagsAlt_r[`FLG_LV] <= |logicResult[7:4];
      end else if (afLoad && afAlt)
        flagsAlt_r <= afData;
    end
  end
  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign waitrequest = (read || write) && !ack_r;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r    <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack_r <= (read || write) && !ack_r;
      if (read && !ack_r) begin
        case (address)
          `OFS_STATUS: readdata <= {22'h0, busy_r, shadow_r, prio_r};
          `OFS_PRIO:   readdata <= {24'h000000, prio_r};
          `OFS_EXTVB:  readdata <= {24'h000000, extVb_r};
          `OFS_INTVB:  readdata <= {24'h000000, intVb_r};
          `OFS_FLAGS:  readdata <= {16'h0000, flagsAlt_r, flags_r};
          `OFS_CTRL:   readdata <= {31'h0, irqEn_r};
          default:     readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: core/opcode_classifier.v
// opcode classifier: class, privilege, dropped opcodes, prefix routing
// assumes op0/op1 are the first two bytes after any alternate/io prefix
`timescale 1ns/1ps
`include "interrupt_priority_privilege_regs.vh"
module opcode_classifier (
  // opcode bytes
  input  wire [7:0] op0,
  input  wire [7:0] op1,
  // class hints for instructions executed elsewhere
  input  wire [1:0] extAltClass,
  input  wire [1:0] extIoClass,
  // results
  output reg  [3:0] cls,
  output reg        privileged,
  output reg        illegal,
  output reg  [1:0] altClass,
  output reg  [1:0] ioClass
);
  wire ed = (op0 == 8'hed);
  wire cb = (op0 == 8'hcb);
  // decode table; altClass is {flags,register}, ioClass is {source,dest}
  always @* begin
    cls        = `CL_NONE;
    privileged = 1'b0;
    illegal    = 1'b0;
    altClass   = extAltClass;
    ioClass    = extIoClass;
    if (ed) begin
      case (op1)
        8'h46, 8'h56, 8'h4e, 8'h5e: begin
          cls = `CL_PRIORITY_PUSH_OP;
          privileged = 1'b1;
          altClass = 2'h0;
        end
        8'h5d: begin
          cls = `CL_PRIORITY_POP_OP;
          privileged = 1'b1;
          altClass = 2'h0;
        end
        8'h7e: begin
          cls = `CL_POPIP;
          privileged = 1'b1;
          altClass = 2'h0;
        end
        8'h76: begin cls = `CL_PUSHIP; altClass = 2'h0; end
        8'h4d: begin cls = `CL_RETI; altClass = 2'h0; end
        8'h47: begin cls = `CL_LDEA; altClass = 2'h0; end
        8'h4f: begin cls = `CL_LDIA; altClass = 2'h0; end
        8'h57: begin cls = `CL_LDAE; altClass = 2'h3; end
        8'h5f: begin cls = `CL_LDAI; altClass = 2'h3; end
        8'h54: begin cls = `CL_EXSP; altClass = 2'h1; end
        8'h67: begin
          privileged = 1'b1;
          altClass = 2'h0;
        end
        8'h77: altClass = 2'h1;
        8'h6f: illegal = 1'b1;
        default: begin
          // block compares and block port transfers are gone
          if (op1[7:5] == 3'h5 && !op1[2] && op1[1:0] != 2'h0) illegal = 1'b1;
        end
      endcase
    end else if (cb && op1[2:0] == 3'h6 && op1[7:6] == 2'h1) begin
      cls = `CL_BIT;
      privileged = 1'b1;
      altClass = 2'h2;
      ioClass = 2'h2;
    end else if (cb && op1[2:0] == 3'h6 && op1[7:6] == 2'h3) begin
      cls = `CL_SET;
      altClass = 2'h0;
      ioClass = 2'h3;
    end else if ((op0 == 8'hdd || op0 == 8'hfd) && op1 == 8'hf9) begin
      privileged = 1'b1;
    end else begin
      case (op0)
        8'hf9: privileged = 1'b1;
        8'h3f: begin cls = `CL_CCF; altClass = 2'h2; end
        8'h37: begin cls = `CL_SCF; altClass = 2'h2; end
        8'he3, 8'h27, 8'h76, 8'hf3, 8'hfb, 8'hd3, 8'hdb: illegal = 1'b1;
        8'hc7, 8'hcf, 8'hf7: illegal = 1'b1;
        default: if (op0[7:6] == 2'h3 && op0[2:0] == 3'h7) cls = `CL_RST;
      endcase
    end
  end
endmodule

// File: inc/interrupt_priority_privilege_regs.vh
// constants for the interrupt priority and privilege unit
// assumes inclusion by bare name from the design files
`ifndef INTERRUPT_PRIORITY_PRIVILEGE_REGS_VH
`define INTERRUPT_PRIORITY_PRIVILEGE_REGS_VH
// ----------------------------------------------------------------
// register word offsets on the bus
// ----------------------------------------------------------------
`define OFS_STATUS 3'h0
`define OFS_PRIO   3'h1
`define OFS_EXTVB  3'h2
`define OFS_INTVB  3'h3
`define OFS_FLAGS  3'h4
`define OFS_CTRL   3'h5
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define STAT_SHADOW 8
`define STAT_BUSY   9
`define CTRL_IRQEN  0
`define FLG_S       7
`define FLG_Z       6
`define FLG_H       4
`define FLG_LV      2
`define FLG_C       0
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PRIO  8'h00
`define RST_VB    8'h00
`define RST_FLAGS 8'h00
`define RST_CTRL  1'h0
// ----------------------------------------------------------------
// instruction classes
// ----------------------------------------------------------------
`define CL_NONE   4'h0
`define CL_PRIORITY_PUSH_OP  4'h1
`define CL_PRIORITY_POP_OP  4'h2
`define CL_POPIP  4'h3
`define CL_PUSHIP 4'h4
`define CL_RETI   4'h5
`define CL_LDEA   4'h6
`define CL_LDIA   4'h7
`define CL_LDAE   4'h8
`define CL_LDAI   4'h9
`define CL_CCF    4'ha
`define CL_SCF    4'hb
`define CL_BIT    4'hc
`define CL_SET    4'hd
`define CL_RST    4'he
`define CL_EXSP   4'hf
// ----------------------------------------------------------------
// clocks per instruction
// ----------------------------------------------------------------
`define CLK_IPOP  4'h4
`define CLK_LDVB  4'h4
`define CLK_CARRY 4'h2
`define CLK_POPIP 4'h7
`define CLK_PUSHIP 4'h9
`define CLK_RETI  4'hc
`define CLK_BIT   4'h7
`define CLK_SET   4'ha
`define CLK_RST   4'ha
`endif

// File: tb/interrupt_priority_privilege_test.sv
// bench: priority stack ops, dropped opcodes, shadow, flags, register bus
// assumes the design header is on the include path
`timescale 1ns/1ps
`include "interrupt_priority_privilege_regs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module interrupt_priority_privilege_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk = 1'b0, nrst = 1'b0, instStart = 1'b0, coreEnd = 1'b0, logicValid = 1'b0, altdIn = 1'b0;
  logic        ioiIn = 1'b0, ioeIn = 1'b0, logicAlt = 1'b0, afLoad = 1'b0, afAlt = 1'b0, irqReq = 1'b0;
  logic        irqExternal = 1'b0, read = 1'b0, write = 1'b0;
  logic [1:0]  extAltClass = 2'h0, extIoClass = 2'h0, irqLevel = 2'h0;
  logic [2:0]  address = 3'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [7:0]  op0 = 8'h00, op1 = 8'h00, accIn = 8'h00, logicResult = 8'h00, afData = 8'h00;
  logic [7:0]  memRdata = 8'h00, irqOffset = 8'h00, wrData;
  logic [15:0] spIn = 16'h1000, hlIn = 16'h2000, pcIn = 16'h0000, wrAddr;
  logic [31:0] writedata = 32'h0, q;
  logic [27:0] rows [14] = '{28'hed4e010, 28'h2700011, 28'hed56060, 28'hc700061, 28'hed5e1b0, 28'hf3001b1,
    28'hed466c0, 28'hed6f6c1, 28'hed5d1b0, 28'heda11b1, 28'hfb001b1, 28'hcf001b1, 28'hf7001b1, 28'he3001b1};
  wire         instIllegal, ready, ownDone_r, memWr_r, irqTake_r, waitrequest, altFlags, altReg, accAlt_r;
  wire [7:0]   memWdata_r, flags_r, accNext_r;
  wire [15:0]  spNext_r, memAddr_r, pcNext_r, irqVector_r;
  wire [31:0]  readdata;
  int          err_count = 0, tests_run = 0, cycles = 0, irqCount = 0, k;
  interrupt_priority_privilege interrupt_priority_privilege_inst (.*, .instOwn(), .ioSrc(), .ioDst(),
    .spLoad_r(), .pcLoad_r(), .accLoad_r(), .flagsAlt_r(), .memRd_r(), .memIo_r());
  always #12.5 core_clk = ~core_clk;
  // capture writes and interrupt takes, cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (memWr_r === 1'b1) wrAddr <= memAddr_r;
    if (memWr_r === 1'b1) wrData <= memWdata_r;
    if (irqTake_r === 1'b1) irqCount <= irqCount + 1;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  // bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  // issue one instruction, check the done cycle
  task automatic inst(input logic [7:0] a, input logic [7:0] b, input int n);
    op0 <= a;
    op1 <= b;
    instStart <= 1'b1;
    @(posedge core_clk);
    instStart <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (ownDone_r !== 1'b1 && k < 40);
    `CHK("done cycle", n, k)
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, q)
    bus(1'b1, `OFS_FLAGS, 32'hff);
    bus(1'b0, 3'h7, 32'h0);
    `CHK("unmapped", 32'h0, q)
    bus(1'b0, `OFS_FLAGS, 32'h0);
    `CHK("flags", 32'h0, q)
    foreach (rows[i]) begin
      op0 <= rows[i][27:20];
      op1 <= rows[i][19:12];
      @(posedge core_clk);
      `CHK("illegal", rows[i][0], instIllegal)
      if (rows[i][0] === 1'b0) inst(rows[i][27:20], rows[i][19:12], 4);
      bus(1'b0, `OFS_PRIO, 32'h0);
      `CHK("prio", rows[i][11:4], q[7:0])
    end
    inst(8'hed, 8'h7e, 7);
    `CHK("pop sp", 16'h1001, spNext_r)
    bus(1'b1, `OFS_CTRL, 32'h1);
    irqLevel <= 2'h2;
    irqOffset <= 8'h40;
    irqReq <= 1'b1;
    inst(8'hed, 8'h4e, 4);
    repeat (2) @(posedge core_clk);
    `CHK("irq shadow", 0, irqCount)
    inst(8'h37, 8'h00, 2);
    coreEnd <= 1'b1;
    @(posedge core_clk);
    coreEnd <= 1'b0;
    repeat (2) @(posedge core_clk);
    irqReq <= 1'b0;
    `CHK("irq taken", 1, irqCount)
    `CHK("vector", 16'h0040, irqVector_r)
    inst(8'hed, 8'h76, 9);
    `CHK("push sp", 16'h0fff, spNext_r)
    `CHK("push addr", 16'h0fff, wrAddr)
    `CHK("push data", 8'h06, wrData)
    inst(8'hcb, 8'h46, 7);
    `CHK("bit zero", 1'b1, flags_r[`FLG_Z])
    inst(8'hcb, 8'hc6, 10);
    `CHK("set zero", 1'b1, flags_r[`FLG_Z])
    `CHK("set data", 8'h01, wrData)
    // interrupt return: stack byte, then two return address bytes
    memRdata <= 8'h33;
    inst(8'hed, 8'h4d, 12);
    `CHK("reti pc", 16'h3333, pcNext_r)
    `CHK("reti sp", 16'h1003, spNext_r)
    bus(1'b0, `OFS_PRIO, 32'h0);
    `CHK("reti prio", 8'h33, q[7:0])
    // restart on the internal base
    bus(1'b1, `OFS_INTVB, 32'h12);
    inst(8'hd7, 8'h00, 10);
    `CHK("rst pc", 16'h1220, pcNext_r)
    `CHK("rst sp", 16'h0ffe, spNext_r)
    // page base through the accumulator, read back into the alternate set
    accIn <= 8'h5a;
    inst(8'hed, 8'h47, 4);
    altdIn <= 1'b1;
    inst(8'hed, 8'h57, 4);
    `CHK("acc", 9'h15a, {accAlt_r, accNext_r})
    `CHK("alt route", 2'h3, {altFlags, altReg})
    altdIn <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      logicResult <= j ? 8'h0f : 8'h10;
      logicValid <= 1'b1;
      @(posedge core_clk);
      logicValid <= 1'b0;
      @(posedge core_clk);
      `CHK("lv", j ? 1'b0 : 1'b1, flags_r[`FLG_LV])
    end
    // reset in mid-run clears the stack and status
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK("reset status", 32'h0, q)
    end_sim();
  end
endmodule

// File: tb/prio_props.sv
// checker: priority stack timing, shadow, flags and dropped restarts
// assumes binding into interrupt_priority_privilege by port names
`timescale 1ns/1ps
`include "interrupt_priority_privilege_regs.vh"
module prio_props (
  // watched ports
  input wire        core_clk,
  input wire        nrst,
  input wire        instStart,
  input wire        ready,
  input wire [7:0]  op0,
  input wire [7:0]  op1,
  input wire [15:0] spIn,
  input wire        ownDone_r,
  input wire        spLoad_r,
  input wire [15:0] spNext_r,
  input wire        memRd_r,
  input wire        memWr_r,
  input wire [15:0] memAddr_r,
  input wire [7:0]  flags_r,
  input wire        logicValid,
  input wire        logicAlt,
  input wire [7:0]  logicResult,
  input wire        instIllegal,
  input wire        irqTake_r
);
  // accepted issues by class
  wire go   = instStart && ready;
  wire pop  = go && op0 == 8'hed && op1 == 8'h7e;
  wire push = go && op0 == 8'hed && op1 == 8'h76;
  wire ips  = go && op0 == 8'hed && op1[7:5] == 3'h2 && op1[2:0] == 3'h6;
  wire bset = go && op0 == 8'hcb && op1[7:6] == 2'h3;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_pop_read: assert property (pop |=> memRd_r && memAddr_r == $past(spIn)) else $error("pop addr");
  a_pop_done: assert property (pop |-> ##7 ownDone_r && spLoad_r && spNext_r == $past(spIn, 7) + 16'h1)
    else $error("pop end");
  a_push_write: assert property (push |=> memWr_r && memAddr_r == $past(spIn) - 16'h1) else $error("push addr");
  a_push_done: assert property (push |-> ##9 ownDone_r && spNext_r == $past(spIn, 9) - 16'h1)
    else $error("push end");
  a_priority_push_op_shadow: assert property (ips |-> ##4 (ownDone_r && !irqTake_r) ##1 !irqTake_r)
    else $error("priority_push_op");
  a_set_flags: assert property (bset |=> $stable(flags_r) [*8]) else $error("set flags");
  a_lv_flag: assert property (logicValid && !logicAlt && ready && !instStart |=>
    flags_r[`FLG_LV] == (|$past(logicResult[7:4]))) else $error("lv flag");
  a_rst_drop: assert property (op0 == 8'hc7 || op0 == 8'hcf || op0 == 8'hf7 |-> instIllegal) else $error("rst");
  // main scenarios reached
  c_pop: cover property (pop);
  c_push: cover property (push);
  c_irq: cover property (irqTake_r);
endmodule
bind interrupt_priority_privilege prio_props prio_props_inst (.*);
